// ---- common/vpfc_defines.vh ----
// Constants for the VBUS port fault control block
// How it works
// - Load switch enable asserted only while in the attached-source state.
// - Discharge output high turns on external VBUS sink; low leaves it off.
// - External fault opens load switch, starts discharge, then error recovery.
// - As source, the fault line nominally stays an output signalling faults; port_fault_line_oe is high only during the internal-fault pulse.
// - Internal fault drives fault line low open-drain, pull-down on, for a while.
// - After the internal-fault pulse, release the line and monitor it again.
// - Companion chip select driven low when addressed, high otherwise.
// - SPI serial clock never exceeds 8 MHz.
// - Active-low orientation output asserted for channel A, deasserted for B.
`ifndef VPFC_DEFINES_VH
`define VPFC_DEFINES_VH

`define VPFC_ST_W 2
`define VPFC_ST_DETACHED 2'h0
`define VPFC_ST_ATTACHED 2'h1
`define VPFC_ST_SAFE 2'h2
`define VPFC_ST_RECOVER 2'h3

`define VPFC_CLK_HZ 125000000
`define VPFC_SPI_MAX_HZ 8000000
// Eight clocks a half period: 125 MHz / 16 stays under the limit
`define VPFC_SPI_DIV_END 16'h0007
`define VPFC_CNT_W 16
`define VPFC_FAULT_PULSE 16'h0100
// Last count of a 1024-cycle recovery
`define VPFC_RECOVER_LAST 16'h03ff
`define VPFC_SPI_BITS 5'h10
`define VPFC_BIT_W 5

`endif

// ---- verilog/vpfc_top.v ----
// VBUS port fault control: load switch, discharge, fault line, companion SPI select
`timescale 1ns/1ps
`include "vpfc_defines.vh"

module vpfc_top (
    input wire clk,
    input wire rst,
    input wire attach_req,
    input wire detach_req,
    input wire orient_a,
    input wire orient_b,
    input wire int_fault,
    input wire [`VPFC_CNT_W-1:0] fault_pulse_cycles,
    input wire port_fault_line_in,
    input wire companion_irq_n,
    input wire spi_miso,
    output reg load_switch_enable,
    output reg vbus_discharge,
    output reg port_fault_line_out,
    output reg port_fault_line_oe,
    output reg port_fault_pulldown,
    output reg orientation_n,
    output reg companion_cs_n,
    output reg spi_sclk,
    output reg spi_mosi,
    output reg [`VPFC_CNT_W-1:0] spi_rx_data,
    output reg spi_rx_valid,
    output reg in_recovery
);

    // =====================================================
    // Port state machine
    reg [`VPFC_ST_W-1:0] state_ff;
    reg [`VPFC_ST_W-1:0] nxt_state;
    reg [`VPFC_CNT_W-1:0] rec_cnt_ff;
    reg [`VPFC_CNT_W-1:0] pulse_cnt_ff;
    reg pulse_ff;
    wire ext_fault;
    wire rec_done;
    wire [`VPFC_CNT_W-1:0] pulse_len;

    // Only a low seen while we are not driving counts as external
    // The pin lags the flag by one cycle, so both mask our own pulse
    assign ext_fault = ~port_fault_line_in & ~pulse_ff & ~port_fault_line_oe;
    // Recovery length is a fixed choice of this block, not of the port
    assign rec_done = (rec_cnt_ff == `VPFC_RECOVER_LAST);
    // A zero length would wrap and run 65536 cycles, so zero picks the default
    assign pulse_len = (fault_pulse_cycles == {`VPFC_CNT_W{1'b0}}) ?
                       `VPFC_FAULT_PULSE : fault_pulse_cycles;

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            `VPFC_ST_DETACHED: begin
                if (attach_req)
                    nxt_state = `VPFC_ST_ATTACHED;
            end
            `VPFC_ST_ATTACHED: begin
                // Fault beats detach so a faulted port always discharges
                if (ext_fault | int_fault)
                    nxt_state = `VPFC_ST_SAFE;
                else if (detach_req)
                    nxt_state = `VPFC_ST_DETACHED;
            end
            `VPFC_ST_SAFE: begin
                if (~pulse_ff)
                    nxt_state = `VPFC_ST_RECOVER;
            end
            `VPFC_ST_RECOVER: begin
                if (rec_done)
                    nxt_state = `VPFC_ST_DETACHED;
            end
            default: nxt_state = `VPFC_ST_DETACHED;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= `VPFC_ST_DETACHED;
            rec_cnt_ff <= {`VPFC_CNT_W{1'b0}};
        end else begin
            state_ff <= nxt_state;
            if (state_ff == `VPFC_ST_RECOVER)
                rec_cnt_ff <= rec_cnt_ff + 16'h0001;
            else
                rec_cnt_ff <= {`VPFC_CNT_W{1'b0}};
        end
    end

    // =====================================================
    // Power outputs
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            load_switch_enable <= 1'b0;
            vbus_discharge <= 1'b0;
            in_recovery <= 1'b0;
        end else begin
            case (nxt_state)
                `VPFC_ST_ATTACHED: begin
                    load_switch_enable <= 1'b1;
                    vbus_discharge <= 1'b0;
                    in_recovery <= 1'b0;
                end
                `VPFC_ST_SAFE: begin
                    load_switch_enable <= 1'b0;
                    vbus_discharge <= 1'b1;
                    in_recovery <= 1'b0;
                end
                `VPFC_ST_RECOVER: begin
                    load_switch_enable <= 1'b0;
                    vbus_discharge <= 1'b1;
                    in_recovery <= 1'b1;
                end
                default: begin
                    load_switch_enable <= 1'b0;
                    vbus_discharge <= 1'b0;
                    in_recovery <= 1'b0;
                end
            endcase
        end
    end

    // =====================================================
    // Fault line driver
    // High while not faulted tells the load switch all is well
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_ff <= 1'b0;
            pulse_cnt_ff <= {`VPFC_CNT_W{1'b0}};
        end else begin
            if (~pulse_ff & int_fault & (state_ff == `VPFC_ST_ATTACHED)) begin
                pulse_ff <= 1'b1;
                pulse_cnt_ff <= pulse_len;
            end else if (pulse_ff) begin
                if (pulse_cnt_ff == 16'h0001)
                    pulse_ff <= 1'b0;
                pulse_cnt_ff <= pulse_cnt_ff - 16'h0001;
            end
        end
    end

    // =====================================================
    // Fault line pins, one cycle behind the pulse flag
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            port_fault_line_out <= 1'b0;
            port_fault_line_oe <= 1'b0;
            port_fault_pulldown <= 1'b0;
        end else begin
            port_fault_line_out <= 1'b0;
            port_fault_line_oe <= pulse_ff;
            port_fault_pulldown <= pulse_ff;
        end
    end
    // Nominal output use is realised by letting the external pull-up show "no fault".
    // Driving high actively would defeat the wired-OR of external sources.

    // =====================================================
    // Orientation
    // Holds the last side seen; A wins when both are reported
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            orientation_n <= 1'b1;
        end else if (orient_a) begin
            orientation_n <= 1'b0;
        end else if (orient_b) begin
            orientation_n <= 1'b1;
        end
    end

    // =====================================================
    // Companion SPI service, one 16-bit read per interrupt
    reg busy_ff;
    reg [`VPFC_CNT_W-1:0] div_ff;
    reg [`VPFC_BIT_W-1:0] bit_ff;
    reg [`VPFC_CNT_W-1:0] shift_ff;
    wire spi_half_done;

    assign spi_half_done = (div_ff == `VPFC_SPI_DIV_END);
    // MOSI carries nothing: no transfer content is defined, so it rests low
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_ff <= 1'b0;
            div_ff <= {`VPFC_CNT_W{1'b0}};
            bit_ff <= {`VPFC_BIT_W{1'b0}};
            shift_ff <= {`VPFC_CNT_W{1'b0}};
            companion_cs_n <= 1'b1;
            spi_sclk <= 1'b0;
            spi_mosi <= 1'b0;
            spi_rx_data <= {`VPFC_CNT_W{1'b0}};
            spi_rx_valid <= 1'b0;
        end else begin
            spi_rx_valid <= 1'b0;
            if (~busy_ff) begin
                if (~companion_irq_n) begin
                    busy_ff <= 1'b1;
                    companion_cs_n <= 1'b0;
                    div_ff <= {`VPFC_CNT_W{1'b0}};
                    bit_ff <= {`VPFC_BIT_W{1'b0}};
                end
            end else if (spi_half_done) begin
                div_ff <= {`VPFC_CNT_W{1'b0}};
                if (bit_ff == `VPFC_SPI_BITS) begin
                    busy_ff <= 1'b0;
                    companion_cs_n <= 1'b1;
                    spi_rx_data <= shift_ff;
                    spi_rx_valid <= 1'b1;
                end else if (~spi_sclk) begin
                    spi_sclk <= 1'b1;
                    shift_ff <= {shift_ff[`VPFC_CNT_W-2:0], spi_miso};
                end else begin
                    spi_sclk <= 1'b0;
                    bit_ff <= bit_ff + 5'h01;
                end
            end else begin
                div_ff <= div_ff + 16'h0001;
            end
        end
    end

endmodule // vpfc_top

// ---- verif/vpfc_props.sv ----
// Checker for the VBUS port fault control ports
`timescale 1ns/1ps
module vpfc_props (
    input wire clk, rst, int_fault, port_fault_line_in, companion_irq_n, load_switch_enable,
    input wire vbus_discharge, port_fault_line_oe, port_fault_pulldown, companion_cs_n, spi_sclk
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ls_only_a: assert property (load_switch_enable |-> !vbus_discharge) else $error("ls");
    ext_trip_a: assert property (load_switch_enable && !port_fault_line_in |=>
        vbus_discharge && !load_switch_enable) else $error("trip");
    pulse_go_a: assert property (load_switch_enable && int_fault |=>
        ##[0:1] port_fault_line_oe) else $error("pulse");
    od_pull_a: assert property (port_fault_line_oe |-> port_fault_pulldown)
        else $error("pd");
    line_free_a: assert property ($fell(port_fault_line_oe) |->
        !port_fault_pulldown && vbus_discharge) else $error("free");
    sclk_half_a: assert property ($rose(spi_sclk) |-> spi_sclk[*8] ##1 !spi_sclk)
        else $error("sclk");
    cs_req_a: assert property ($fell(companion_cs_n) |-> !$past(companion_irq_n))
        else $error("cs");
    cs_idle_a: assert property (companion_cs_n |-> !spi_sclk) else $error("idle");
endmodule // vpfc_props
bind vpfc_top vpfc_props chk_u (.clk(clk), .rst(rst), .int_fault(int_fault),
    .port_fault_line_in(port_fault_line_in), .companion_irq_n(companion_irq_n),
    .load_switch_enable(load_switch_enable), .vbus_discharge(vbus_discharge),
    .port_fault_line_oe(port_fault_line_oe), .port_fault_pulldown(port_fault_pulldown),
    .companion_cs_n(companion_cs_n), .spi_sclk(spi_sclk));

// ---- verif/vpfc_partner.sv ----
// Companion controller model beyond the SPI link
`timescale 1ns/1ps
module vpfc_partner (
    input wire spi_sclk, companion_cs_n, irq_req,
    output wire companion_irq_n, output reg spi_miso = 1'b0
);
    reg [15:0] sh_ff = 16'h0000;
    assign companion_irq_n = !irq_req;
    always @(negedge companion_cs_n) sh_ff = 16'ha5c3;
    always @(negedge spi_sclk) sh_ff = sh_ff << 1;
    // Deselected: flip, so a stale bit never reads as data
    always @(sh_ff or companion_cs_n) spi_miso = companion_cs_n ? ~spi_miso : sh_ff[15];
endmodule // vpfc_partner

// ---- verif/tb_vpfc_top.sv ----
// Testbench for the VBUS port fault control block
`timescale 1ns/1ps
module tb_vpfc_top;
    logic clk = 0, rst = 1, attach_req = 0, detach_req = 0, orient_a = 1, orient_b = 0;
    logic int_fault = 0, ext_fault = 0, irq_req = 0;
    logic [15:0] fault_pulse_cycles = 16'h0005;
    wire port_fault_line_in, companion_irq_n, spi_miso, load_switch_enable, vbus_discharge;
    wire port_fault_line_out, port_fault_line_oe, port_fault_pulldown, orientation_n;
    wire companion_cs_n, spi_sclk, spi_mosi, spi_rx_valid, in_recovery;
    wire [15:0] spi_rx_data;
    int bad_count = 0, total_checks = 0, n = 0;
    vpfc_top dut_u (.*);
    vpfc_partner far_u (.*);
    assign port_fault_line_in = !(ext_fault || port_fault_line_oe);
    always #4 clk = ~clk;
    always @(posedge clk) n += (port_fault_line_oe === 1'b1);
    task cyc(input int k);
        repeat (k) @(posedge clk) #1;
    endtask
    task chk(input logic ok, input string m);
        total_checks++;
        bad_count += (ok !== 1'b1);
        if (ok !== 1'b1)
            $display("ERROR %0t %s", $time, m);
    endtask
    task conclude(input int late);
        bad_count += late;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task attach;
        attach_req = 1;
        cyc(1);
        attach_req = 0;
        cyc(2);
    endtask
    task t_ext;
        attach();
        chk(load_switch_enable === 1'b1 && orientation_n === 1'b0, "on");
        ext_fault = 1;
        cyc(3);
        ext_fault = 0;
        chk(load_switch_enable === 1'b0 && vbus_discharge === 1'b1, "trip");
        cyc(1022);
        chk(in_recovery === 1'b1 && vbus_discharge === 1'b1, "rec short");
        cyc(1);
        chk(vbus_discharge === 1'b0 && in_recovery === 1'b0, "rec");
    endtask
    task t_int;
        attach();
        int_fault = 1;
        cyc(1);
        int_fault = 0;
        cyc(2);
        chk(port_fault_line_oe === 1'b1 && port_fault_pulldown === 1'b1 &&
            port_fault_line_out === 1'b0 && vbus_discharge === 1'b1, "drive");
        cyc(28);
        chk(n == 5 && port_fault_line_oe === 1'b0 && port_fault_pulldown === 1'b0, "pulse");
    endtask
    task t_rst;
        int base;
        rst = 1;
        #1;
        chk(load_switch_enable === 1'b0 && vbus_discharge === 1'b0 && orientation_n === 1'b1 &&
            companion_cs_n === 1'b1 && port_fault_line_oe === 1'b0, "mid rst");
        cyc(2);
        rst = 0;
        attach();
        chk(load_switch_enable === 1'b1 && orientation_n === 1'b0, "reattach");
        orient_a = 0;
        orient_b = 1;
        detach_req = 1;
        cyc(1);
        detach_req = 0;
        chk(load_switch_enable === 1'b0 && vbus_discharge === 1'b0 && orientation_n === 1'b1,
            "detach");
        fault_pulse_cycles = 16'h0000;
        attach();
        base = n;
        int_fault = 1;
        cyc(1);
        int_fault = 0;
        cyc(300);
        chk(n - base == 256 && port_fault_line_oe === 1'b0, "default pulse");
    endtask
    task t_spi;
        irq_req = 1;
        cyc(2);
        irq_req = 0;
        chk(companion_cs_n === 1'b0 && spi_mosi === 1'b0, "select");
        for (int i = 0; i < 400 && spi_rx_valid !== 1'b1; i++) cyc(1);
        chk(spi_rx_data === 16'ha5c3 && companion_cs_n === 1'b1, "spi");
    endtask
    initial begin
        cyc(2);
        chk(load_switch_enable === 1'b0 && companion_cs_n === 1'b1, "rst");
        cyc(8);
        rst = 0;
        t_ext();
        t_int();
        t_spi();
        t_rst();
        conclude(0);
    end
    initial #200000 conclude(1);
endmodule // tb_vpfc_top
